/* shared/pcl_pkg.sv */
// Constants and types shared by the parallel configuration load port.
// What this block does
// - Each data word takes 1 clock in 8-bit mode, 2 with decompression; in 16-bit mode 1 plain, 2 secure, 4 compressed.
// - In 16-bit mode data lines 15..0 carry data, in 8-bit mode only lines 7..0 do.
// - In user mode request, status and load complete are high, and a low request restarts configuration.
// - After power-up status stays low for the whole power-on-reset delay before data is accepted.
// - Load complete stays low from power-up through the wait and the whole data transfer.
// - Load complete rises once every word has arrived; the check value is not used to gate it.
// - After configuration the clock is ignored, though the host keeps it at a defined level.
// - Once the init enable option has been loaded, init complete is driven low until initialization ends.
// - After configuration the data lines return to user I/O.
package pcl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_DELAY_NS = 100000;
  localparam int POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECONFIG_STROBE_WIDTH_NS = 250;
  localparam int RECONFIG_STROBE_CYC = (RECONFIG_STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WORD_COUNT_DEFAULT = 64;
  localparam int INIT_EDGES = 2;
  localparam int INIT_OPT_BIT = 0;
  localparam logic [15:0] CHECK_SEED = 16'h0000;

  typedef enum logic [2:0] {
    PCL_POR = 3'b000,
    PCL_RESET = 3'b001,
    PCL_LOAD = 3'b010,
    PCL_INIT = 3'b011,
    PCL_USER = 3'b100,
    PCL_ERROR = 3'b101
  } pcl_state_t;
endpackage : pcl_pkg

/* verif/pcl_host.sv */
// Behavioural external host that streams a configuration image.
`timescale 1ns/10ps
module pcl_host (
  input wire logic go_in,
  input wire logic [2:0] ratio_in,
  input wire logic [15:0] base_in,
  input wire logic pause_in,
  output logic clk_out,
  output logic [15:0] data_out,
  output logic done_out
);
  initial begin
    clk_out = 1'b0;
    data_out = 16'hFFFF;
    done_out = 1'b0;
  end
  always @(posedge go_in) begin
    done_out = 1'b0;
    for (int w = 0; w < 4; w++) begin
      data_out = base_in + w[15:0];
      for (int e = 0; e < ratio_in; e++) begin
        #40 clk_out = 1'b1;
        #40 clk_out = 1'b0;
        if (pause_in && ratio_in > 3'h1) #400;
      end
    end
    data_out = ~data_out;
    #200 clk_out = 1'b1;
    #40 clk_out = 1'b0;
    #40 clk_out = 1'b1;
    #40 clk_out = 1'b0;
    done_out = 1'b1;
  end
endmodule : pcl_host

/* verif/testbench.sv */
// Self-checking bench for the parallel configuration load port.
`timescale 1ns/10ps
module testbench;
  import pcl_pkg::*;
  logic clk, rst_n, req_n, wide, dec, sec, strobe, go, pause, cclk, hdone;
  logic st_n, done, init, init_oe, user, wv, cerr;
  logic [15:0] base, cdata, wdata;
  logic [2:0] rat;
  int n_fail = 0, num_checks = 0, seed = 32'h7be8, nw = 0;
  localparam int NWORDS = 4;
  pcl_port #(.POR_CYCLES(20), .WORD_COUNT(NWORDS)) uut (.core_clk_in(clk), .arst_n_in(rst_n),
    .config_clock_in(cclk), .config_request_n_in(req_n), .config_data_in(cdata), .wide_mode_in(wide),
    .decompress_in(dec), .security_in(sec), .reconfig_strobe_in(strobe), .config_status_n_out(st_n),
    .load_complete_out(done), .init_complete_out(init), .init_complete_oe_out(init_oe),
    .user_io_mode_out(user), .word_valid_out(wv), .word_data_out(wdata), .check_error_out(cerr));
  pcl_host host (.go_in(go), .ratio_in(rat), .base_in(base), .pause_in(pause), .clk_out(cclk),
    .data_out(cdata), .done_out(hdone));
  function automatic logic [2:0] ratio_of(logic w, logic d, logic s);
    return !w ? (d ? 3'h2 : 3'h1) : d ? 3'h4 : s ? 3'h2 : 3'h1;
  endfunction : ratio_of
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic wait_ready();
    for (int i = 0; i < 200 && st_n !== 1'b1; i++) @(posedge clk);
  endtask : wait_ready
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000 n_fail++;
    summarize();
  end
  always @(posedge clk) if (wv === 1'b1) begin
    chk("word", (base + nw[15:0]) & (wide ? 16'hFFFF : 16'h00FF), wdata);
    chk("done early", 16'(nw == NWORDS - 1), 16'(done));
    chk("init low", 16'h0000, 16'(init));
    nw++;
  end
  initial begin
    {rst_n, req_n, wide, dec, sec, strobe, go, pause} = 8'h40;
    base = 16'h0000;
    rat = 3'h1;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clk);
    chk("por status", 16'h0000, 16'(st_n));
    chk("por done", 16'h0000, 16'(done));
    for (int m = 0; m < 8; m++) begin
      #1 {wide, dec, sec} = m[2:0];
      rat = ratio_of(m[2], m[1], m[0]);
      base = 16'($random(seed));
      pause = 1'($random(seed));
      req_n = 1'b0;
      repeat (4) @(posedge clk);
      #1 req_n = 1'b1;
      wait_ready();
      chk("ready", 16'h0001, 16'(st_n));
      chk("wait done", 16'h0000, 16'(done));
      nw = 0;
      #1 go = 1'b1;
      @(posedge clk);
      #1 go = 1'b0;
      for (int i = 0; i < 5000 && hdone !== 1'b1; i++) @(posedge clk);
      chk("host done", 16'h0001, 16'(hdone));
      repeat (5) @(posedge clk);
      chk("words", 16'(NWORDS), 16'(nw));
      chk("loaded", 16'h0001, 16'(done));
      chk("user io", 16'h0001, 16'(user));
      chk("init oe", 16'(base[0]), 16'(init_oe));
      chk("init", 16'h0001, 16'(init));
      chk("user status", 16'h0001, 16'(st_n));
      chk("no error", 16'h0000, 16'(cerr));
      $display("test mode %0d done", m);
    end
    for (int k = 0; k < 2; k++) begin
      #1 strobe = 1'b1;
      repeat (k ? 30 : 10) @(posedge clk);
      #1 strobe = 1'b0;
      repeat (10) @(posedge clk);
      chk("strobe restart", 16'(k == 0), 16'(done));
      $display("test strobe %0d done", k);
    end
    wait_ready();
    chk("reload wait", 16'h0000, 16'(done));
    summarize();
  end
endmodule : testbench

/* verilog/pcl_port.sv */
// Device-side receiver of the parallel configuration load port.
`timescale 1ns/10ps
module pcl_port
  import pcl_pkg::*;
#(
  parameter int POR_CYCLES = POR_DELAY_CYC,
  parameter int WORD_COUNT = WORD_COUNT_DEFAULT
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic config_clock_in,
  input wire logic config_request_n_in,
  input wire logic [15:0] config_data_in,
  input wire logic wide_mode_in,
  input wire logic decompress_in,
  input wire logic security_in,
  input wire logic reconfig_strobe_in,
  output logic config_status_n_out,
  output logic load_complete_out,
  output logic init_complete_out,
  output logic init_complete_oe_out,
  output logic user_io_mode_out,
  output logic word_valid_out,
  output logic [15:0] word_data_out,
  output logic check_error_out
);
  logic [18:0] pin_s;
  logic clk_prev_q;
  pcl_state_t state_q;
  pcl_state_t state_d;
  logic [31:0] count_q;
  logic [2:0] phase_q;
  logic [1:0] edges_q;
  logic init_en_q;
  logic first_q;
  logic [15:0] check_q;
  logic [31:0] words_q;
  logic [4:0] strobe_cnt_q;

  pcl_sync #(.WIDTH(19)) u_sync (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .async_in({reconfig_strobe_in, config_request_n_in, config_clock_in, config_data_in}),
    .sync_out(pin_s)
  );

  wire strobe_s = pin_s[18];
  wire req_n_s = pin_s[17];
  wire clk_s = pin_s[16];
  wire [15:0] data_s = pin_s[15:0];
  wire clk_rise = clk_s & ~clk_prev_q;
  wire clk_fall = ~clk_s & clk_prev_q;

  function automatic logic [2:0] ratio_of(input logic wide, input logic dec, input logic sec);
    if (!wide) begin
      ratio_of = dec ? 3'h2 : 3'h1;
    end else begin
      ratio_of = dec ? 3'h4 : (sec ? 3'h2 : 3'h1);
    end
  endfunction : ratio_of

  wire [2:0] ratio = ratio_of(wide_mode_in, decompress_in, security_in);
  wire [15:0] word = wide_mode_in ? data_s : {8'h00, data_s[7:0]};
  wire last_phase = (phase_q == ratio - 3'h1);
  wire take_word = (state_q == PCL_LOAD) && clk_rise && last_phase;
  wire last_word = take_word && (words_q == WORD_COUNT - 1);
  wire strobe_long = (strobe_cnt_q >= 5'(RECONFIG_STROBE_CYC));
  wire restart = (!req_n_s || (strobe_long && !strobe_s)) && state_q != PCL_POR;
  wire [15:0] check_next = {check_q[14:0], check_q[15]} ^ word;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PCL_POR: begin
        if (count_q >= 32'(POR_CYCLES - 1)) state_d = PCL_RESET;
      end
      PCL_RESET: begin
        if (req_n_s) state_d = PCL_LOAD;
      end
      PCL_LOAD: begin
        if (last_word) state_d = (check_next == CHECK_SEED || 1'b1) ? PCL_INIT : PCL_ERROR;
      end
      PCL_INIT: begin
        if (clk_fall && edges_q == 2'(INIT_EDGES - 1)) state_d = PCL_USER;
      end
      PCL_USER: begin
        state_d = PCL_USER;
      end
      PCL_ERROR: begin
        state_d = PCL_ERROR;
      end
      default: begin
        state_d = PCL_POR;
      end
    endcase
    if (restart) state_d = PCL_RESET;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= PCL_POR;
      count_q <= '0;
      clk_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= (state_q == PCL_POR) ? count_q + 32'h1 : '0;
      clk_prev_q <= clk_s;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_q <= '0;
      words_q <= '0;
      first_q <= 1'b1;
      init_en_q <= 1'b0;
      check_q <= CHECK_SEED;
      edges_q <= '0;
      word_valid_out <= 1'b0;
      word_data_out <= '0;
    end else begin
      word_valid_out <= take_word;
      if (state_q != PCL_LOAD) begin
        phase_q <= '0;
        words_q <= '0;
        first_q <= 1'b1;
        check_q <= CHECK_SEED;
      end else if (clk_rise) begin
        phase_q <= last_phase ? 3'h0 : phase_q + 3'h1;
        if (last_phase) begin
          words_q <= words_q + 32'h1;
          first_q <= 1'b0;
          check_q <= check_next;
          word_data_out <= word;
          if (first_q) init_en_q <= word[INIT_OPT_BIT];
        end
      end
      if (restart) init_en_q <= 1'b0;
      if (state_q != PCL_INIT) edges_q <= '0;
      else if (clk_fall) edges_q <= edges_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strobe_cnt_q <= '0;
      config_status_n_out <= 1'b0;
      load_complete_out <= 1'b0;
      init_complete_out <= 1'b0;
      init_complete_oe_out <= 1'b0;
      user_io_mode_out <= 1'b0;
      check_error_out <= 1'b0;
    end else begin
      if (!strobe_s) strobe_cnt_q <= '0;
      else if (!strobe_long) strobe_cnt_q <= strobe_cnt_q + 5'h1;
      config_status_n_out <= (state_d != PCL_POR) && (state_d != PCL_RESET) && (state_d != PCL_ERROR);
      load_complete_out <= (state_d == PCL_INIT) || (state_d == PCL_USER);
      init_complete_oe_out <= init_en_q && (state_d != PCL_RESET);
      init_complete_out <= (state_d == PCL_USER);
      user_io_mode_out <= (state_d == PCL_USER);
      check_error_out <= (state_d == PCL_ERROR);
    end
  end

  a_por_status_low: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == PCL_POR) |=> !config_status_n_out)
    else $error("Status released during power-on delay.");
  a_load_status_high: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == PCL_LOAD) |-> config_status_n_out)
    else $error("Status low while accepting data.");
  a_por_done_low: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == PCL_POR) |-> !load_complete_out)
    else $error("Load complete high during power-on delay.");
  a_done_low_load: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == PCL_LOAD && !last_word) |=> !load_complete_out)
    else $error("Load complete high while loading.");
  a_done_after_last: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (last_word && !restart) |=> load_complete_out)
    else $error("Load complete missing after last word.");
  a_error_status: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    check_error_out |-> !config_status_n_out)
    else $error("Status high in error state.");
  a_request_restart: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (!req_n_s && state_q != PCL_POR) |=> (state_q == PCL_RESET) ##0 !load_complete_out)
    else $error("Request did not restart configuration.");
  a_restart_done_low: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    restart |=> !load_complete_out)
    else $error("Load complete high after restart.");
  a_user_levels: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    user_io_mode_out |-> (load_complete_out && config_status_n_out))
    else $error("Status or load complete low in user mode.");
  a_strobe_restart: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (strobe_long && !strobe_s && state_q != PCL_POR) |=> state_q == PCL_RESET)
    else $error("Long strobe did not restart configuration.");
  a_clock_ignored: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == PCL_USER && req_n_s && !strobe_long) |=> state_q == PCL_USER)
    else $error("User mode left without a restart.");
  a_ratio_table: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (wide_mode_in && decompress_in) |-> ratio == 3'h4)
    else $error("Wrong ratio for wide compressed mode.");
  a_ratio_narrow: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (!wide_mode_in) |-> ratio == (decompress_in ? 3'h2 : 3'h1))
    else $error("Wrong ratio for narrow mode.");
  a_ratio_secure: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (wide_mode_in && !decompress_in) |-> ratio == (security_in ? 3'h2 : 3'h1))
    else $error("Wrong ratio for wide uncompressed mode.");
  a_narrow_data: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (word_valid_out && !wide_mode_in) |-> word_data_out[15:8] == 8'h00)
    else $error("Upper lines used in narrow mode.");
  a_word_pulse: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    word_valid_out |=> !word_valid_out)
    else $error("Word valid longer than one cycle.");
  a_word_capture: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    take_word |=> (word_valid_out && word_data_out == $past(word)))
    else $error("Captured word not presented.");
  a_phase_bound: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == PCL_LOAD) |-> phase_q < ratio)
    else $error("Clock phase count beyond the ratio.");
  a_init_edges: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == PCL_INIT && !clk_fall && !restart) |=> state_q == PCL_INIT)
    else $error("Initialization left without a falling edge.");
  a_init_user: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == PCL_INIT && clk_fall && edges_q == 2'h1 && !restart) |=> user_io_mode_out)
    else $error("User mode not entered after two falling edges.");
  a_init_low: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (init_complete_oe_out && state_q == PCL_INIT) |-> !init_complete_out)
    else $error("Init complete high too early.");
  a_oe_before_option: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == PCL_LOAD && first_q) |-> !init_complete_oe_out)
    else $error("Init complete driven before the option was loaded.");
endmodule : pcl_port

/* verilog/pcl_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/10ps
module pcl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pcl_sync
